// File: dual_mux_latch.sv
// Purpose: Two 2-input muxes each feeding a latch, shared select and reset
// Assumes: Pins sampled through two flops; registers over Avalon-MM
// Notes: Latch modelled as a flop updated while its effective clock is low
//
// Functional notes
// - One select and one reset shared
// - Each half clocked alone by its enable
// - Select high routes each second input
// - Select low routes each first input
// - Effective clock low: output follows data
// - Rising effective clock captures selected data
// - Effective clock high: output holds
// - Reset acts only while clock high
`include "mux_latch_map.svh"
module dual_mux_latch (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pins from surrounding logic
  input wire logic sel_pin_i,
  input wire logic reset_pin_i,
  input wire logic shared_clock_i,
  input wire logic en1_n_pin_i,
  input wire logic en2_n_pin_i,
  input wire logic half1_in_low_i,
  input wire logic half1_in_high_i,
  input wire logic half2_in_low_i,
  input wire logic half2_in_high_i,
  // Pin-or-register source select
  input wire logic use_regs_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Latch outputs
  output logic q1_o,
  output logic q2_o
);
  // ==========================================
  // Input synchronisers
  // Pins arrive from another domain; stage one may go metastable.
  // Cost: two cycles of latency on every pin before a latch sees it.
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r; // First stage, read only by second
  logic [NPIN-1:0] pin_s2_r; // Safe to use
  logic use_s1_r;
  logic use_s2_r;
  assign pin_raw = {half2_in_high_i, half2_in_low_i, half1_in_high_i, half1_in_low_i,
                    en2_n_pin_i, en1_n_pin_i, shared_clock_i, reset_pin_i, sel_pin_i};

  // Two flops per pin, no logic between
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      use_s1_r <= 1'b0;
      use_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      use_s1_r <= use_regs_i;
      use_s2_r <= use_s1_r;
    end
  end

  // ==========================================
  // Control register, lets software drive the latch inputs instead of pins
  // Useful for a host that wants the halves with no pins wired at all
  logic [8:0] ctrl_r;
  logic [8:0] src;
  assign src = use_s2_r ? ctrl_r : pin_s2_r;

  // Named views of the chosen source
  wire sel = src[`ML_SEL_BIT];
  wire rst_shared = src[`ML_RST_BIT];
  wire clk_c = src[`ML_CLK_BIT];
  // Enables gate the common clock; driver holds them low to use it
  wire eclk1 = clk_c | src[`ML_EN1_N_BIT];
  wire eclk2 = clk_c | src[`ML_EN2_N_BIT];
  wire d1 = sel ? src[`ML_D1H_BIT] : src[`ML_D1L_BIT];
  wire d2 = sel ? src[`ML_D2H_BIT] : src[`ML_D2L_BIT];

  // ==========================================
  // Latch halves
  // Low clock: follow data, reset ignored; high clock: hold unless reset.
  // Rising edge keeps the value sampled in the last low cycle.
  // Reset only acts in the hold branch, so a transparent half ignores it.
  // Limitation: a pin pulse shorter than one clock may be missed entirely.
  wire q1_nxt = !eclk1 ? d1 : (rst_shared ? 1'b0 : q1_o);
  wire q2_nxt = !eclk2 ? d2 : (rst_shared ? 1'b0 : q2_o);

  // Storage flops; capture on rise falls out of the hold branch
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q1_o <= 1'b0;
      q2_o <= 1'b0;
    end else begin
      q1_o <= q1_nxt;
      q2_o <= q2_nxt;
    end
  end

  // ==========================================
  // Avalon-MM slave, one wait cycle on every access
  mux_latch_pkg::bus_state_t bus_r;
  wire req = avs_read_i | avs_write_i;
  wire hit_ctrl = (avs_address_i == `ML_CTRL_OFS);
  wire hit_stat = (avs_address_i == `ML_STAT_OFS);
  wire do_wr = (bus_r == mux_latch_pkg::BUS_ACK) && avs_write_i && hit_ctrl;
  logic [31:0] rd_mux;
  // Decode read data
  // Status word: q1, q2, active source, then both effective clocks
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {23'h000000, ctrl_r};
    end else if (hit_stat) begin
      rd_mux = {19'h00000, eclk2, eclk1, src, q2_o, q1_o};
    end else begin
      rd_mux = `ML_UNMAPPED_DATA;
    end
  end

  // Handshake: waitrequest low for one cycle after request seen
  // Read word is captured on the request edge and stays until the next
  // access, so the master finds it when it samples waitrequest low.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_r <= mux_latch_pkg::BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      ctrl_r <= `ML_CTRL_RST;
    end else begin
      case (bus_r)
        mux_latch_pkg::BUS_IDLE: begin
          if (req) begin
            bus_r <= mux_latch_pkg::BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= rd_mux;
          end
        end
        default: begin
          bus_r <= mux_latch_pkg::BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
      // Byte lanes 0 and 1 carry the nine control bits
      // Upper lanes carry nothing; their data is dropped
      if (do_wr && avs_byteenable_i[0]) begin
        ctrl_r[7:0] <= avs_writedata_i[7:0];
      end
      if (do_wr && avs_byteenable_i[1]) begin
        ctrl_r[8] <= avs_writedata_i[8];
      end
    end
  end

  // ==========================================
  // Checks
  // Properties sample the synced sources, so cycle counts match the
  // register stage behind them, not the raw pins.
  sequence s_low1;
    !eclk1;
  endsequence
  // Bus request seen while idle
  sequence s_req_idle;
    (bus_r == mux_latch_pkg::BUS_IDLE) && req;
  endsequence
  // Answer: one low cycle of waitrequest, then high again
  sequence s_ack_pulse;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  AST_FOLLOW1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_low1 |=> (q1_o == $past(d1))) else $error("half1 not transparent");
  AST_FOLLOW2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !eclk2 |=> (q2_o == $past(d2))) else $error("half2 not transparent");
  AST_HOLD1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (eclk1 && !rst_shared) |=> $stable(q1_o)) else $error("half1 changed while held");
  AST_HOLD2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (eclk2 && !rst_shared) |=> $stable(q2_o)) else $error("half2 changed while held");
  AST_CAPT1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(eclk1) && !rst_shared) |-> (q1_o == $past(d1))) else $error("half1 bad capture");
  AST_RESET1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (eclk1 && rst_shared) |=> !q1_o) else $error("half1 reset failed");
  AST_RESET2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (eclk2 && rst_shared) |=> !q2_o) else $error("half2 reset failed");
  AST_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk1 && sel) |=> (q1_o == $past(src[`ML_D1H_BIT]))) else $error("select high wrong");
  AST_ECLK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!clk_c && !src[`ML_EN2_N_BIT]) |-> !eclk2) else $error("enable gating wrong");
  // Select low picks the first input of each half
  AST_SEL_LO1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk1 && !sel) |=> (q1_o == $past(src[`ML_D1L_BIT]))) else $error("half1 select low wrong");
  AST_SEL_LO2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk2 && !sel) |=> (q2_o == $past(src[`ML_D2L_BIT]))) else $error("half2 select low wrong");
  // Select high picks the second input of half two as well
  AST_SEL2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk2 && sel) |=> (q2_o == $past(src[`ML_D2H_BIT]))) else $error("half2 select high wrong");
  // Rising effective clock keeps the last transparent value
  AST_CAPT2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(eclk2) && !rst_shared) |-> (q2_o == $past(d2))) else $error("half2 bad capture");
  // Transparent half must not be cleared by the shared reset
  AST_IGNRST1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk1 && rst_shared && d1) |=> q1_o) else $error("half1 reset not ignored");
  AST_IGNRST2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!eclk2 && rst_shared && d2) |=> q2_o) else $error("half2 reset not ignored");
  // Bus answers every idle request with a single low waitrequest cycle
  AST_BUS_ANS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_req_idle |=> s_ack_pulse) else $error("bus answer timing wrong");
  // Full-lane write to the control register lands as written
  AST_CTRL_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (do_wr && avs_byteenable_i[0] && avs_byteenable_i[1])
    |=> (ctrl_r == $past(avs_writedata_i[8:0]))) else $error("control write lost");
  // Writes to any other offset leave the control register alone
  AST_CTRL_REFUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((bus_r == mux_latch_pkg::BUS_ACK) && avs_write_i && !hit_ctrl)
    |=> $stable(ctrl_r)) else $error("refused write changed control");
  // Block reset clears both halves and parks the bus
  AST_SYNC_RST: assert property (@(posedge ref_clk_i)
    rst_i |=> (!q1_o && !q2_o && avs_waitrequest_o)) else $error("block reset wrong");
endmodule

// File: mux_latch_map.svh
// Purpose: Constants for the dual mux latch block and its register map
// Assumes: Included by its bare name
// Notes: Offsets are byte addresses on a 32-bit Avalon-MM slave
`ifndef MUX_LATCH_MAP_SVH
`define MUX_LATCH_MAP_SVH
// ==========================================
// Register offsets
`define ML_CTRL_OFS 4'h0
`define ML_STAT_OFS 4'h4
// ==========================================
// Control field positions
`define ML_SEL_BIT 0
`define ML_RST_BIT 1
`define ML_CLK_BIT 2
`define ML_EN1_N_BIT 3
`define ML_EN2_N_BIT 4
`define ML_D1L_BIT 5
`define ML_D1H_BIT 6
`define ML_D2L_BIT 7
`define ML_D2H_BIT 8
// ==========================================
// Reset value and unmapped read data
`define ML_CTRL_RST 9'h018
`define ML_UNMAPPED_DATA 32'hdeadbeef
`endif

// File: mux_latch_pkg.sv
// Purpose: Types for the dual mux latch block
// Assumes: Nothing else
// Notes: Bus slave states only
package mux_latch_pkg;
  // ==========================================
  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;
endpackage

// File: pins_model.sv
// Purpose: Behavioural model of the logic that drives the latch pins
// Assumes: One command vector, laid out like the control register
// Notes: Registered, so pins change just after a clock edge
module pins_model (
  // Clock and command
  input wire logic ref_clk_i,
  input wire logic [8:0] cmd_i,
  // Pin vector towards the block
  output logic [8:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Pin driver
  // Shared clock high forces both enables low so they gate it
  always_ff @(posedge ref_clk_i) begin
    pins_o <= cmd_i[2] ? (cmd_i & 9'h1e7) : cmd_i;
  end
endmodule

// File: test_dual_mux_latch.sv
// Purpose: Self-checking bench for the dual mux latch block
// Assumes: Pins through pins_model, registers over Avalon-MM
// Notes: Waits of five cycles cover model flop plus two-flop sync
module test_dual_mux_latch;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, use_regs = 1'b0, rd = 1'b0, wr = 1'b0;
  logic wq, q1, q2;
  logic [8:0] cmd = 9'h018, pins;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  int error_cnt = 0, n_tests = 0;
  always #2.5 ref_clk = ~ref_clk;
  pins_model far (.ref_clk_i(ref_clk), .cmd_i(cmd), .pins_o(pins));
  dual_mux_latch dut (.ref_clk_i(ref_clk), .rst_i(rst), .sel_pin_i(pins[0]),
    .reset_pin_i(pins[1]), .shared_clock_i(pins[2]), .en1_n_pin_i(pins[3]),
    .en2_n_pin_i(pins[4]), .half1_in_low_i(pins[5]), .half1_in_high_i(pins[6]),
    .half2_in_low_i(pins[7]), .half2_in_high_i(pins[8]), .use_regs_i(use_regs),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wq), .q1_o(q1), .q2_o(q2));
  // ==========================================
  // Bus and check tasks
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge ref_clk); while (wq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Drive a pin vector, let it settle, compare {q2,q1}
  task automatic put(input logic [8:0] v, input logic [1:0] e);
    @(posedge ref_clk);
    cmd <= v;
    repeat (5) @(posedge ref_clk);
    #1 chk({30'h0, q2, q1}, {30'h0, e});
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // Watchdog, far beyond the expected hundred or so cycles
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk(got, 32'h18);
    bus(1'b0, 4'h8, 32'h0);
    chk(got, 32'hdeadbeef);
    put(9'h0a0, 2'b11);
    put(9'h0a1, 2'b00);
    put(9'h141, 2'b11);
    put(9'h145, 2'b11);
    put(9'h004, 2'b11);
    put(9'h006, 2'b00);
    put(9'h0a2, 2'b11);
    put(9'h0aa, 2'b10);
    put(9'h028, 2'b00);
    put(9'h020, 2'b01);
    put(9'h01a, 2'b00);
    // Register source: latches follow the control register
    @(posedge ref_clk);
    use_regs <= 1'b1;
    bus(1'b1, 4'h0, 32'h0a0);
    bus(1'b1, 4'hc, 32'h1ff);
    repeat (5) @(posedge ref_clk);
    bus(1'b0, 4'h0, 32'h0);
    chk(got, 32'h0a0);
    bus(1'b0, 4'h4, 32'h0);
    chk(got, 32'h283);
    summarize();
  end
endmodule
